// File: design/mcie_pkg.sv
package mcie_pkg;
    // ------------------------------------------------------------
    // Instruction codes
    // ------------------------------------------------------------
    localparam logic [7:0] OP_ROTATE_CW = 8'h01;
    localparam logic [7:0] OP_ROTATE_CCW = 8'h02;
    localparam logic [7:0] OP_SOFT_STOP = 8'h03;
    localparam logic [7:0] OP_GLOBAL_PARAM_WRITE = 8'h09;
    localparam logic [7:0] OP_JUMP = 8'h16;
    localparam logic [7:0] OP_IRQ_ENABLE = 8'h19;
    localparam logic [7:0] OP_IRQ_DISABLE = 8'h1a;
    localparam logic [7:0] OP_VECTOR_DEFINE = 8'h25;
    localparam logic [7:0] OP_HANDLER_RETURN = 8'h26;
    localparam logic [7:0] IRQ_BANK = 8'h03;
    localparam logic [7:0] IRQ_GLOBAL_NUM = 8'hff;
    // ------------------------------------------------------------
    // Interrupt numbers by source index
    // ------------------------------------------------------------
    localparam int IRQ_SRC_N = 11;
    localparam int TIMER_N = 3;
    localparam logic [IRQ_SRC_N-1:0][7:0] IRQ_NUM = {
        8'h29, 8'h28, 8'h27, 8'h1c, 8'h1b, 8'h15, 8'h0f,
        8'h03, 8'h02, 8'h01, 8'h00};
    // ------------------------------------------------------------
    // Frame layout and reply codes
    // ------------------------------------------------------------
    localparam int FRAME_LEN = 9;
    localparam logic [3:0] FRAME_LAST = 4'h8;
    localparam logic [7:0] ST_OK = 8'h64;
    localparam logic [7:0] ST_BAD_SUM = 8'h01;
    localparam logic [7:0] ST_BAD_CMD = 8'h02;
    localparam logic [7:0] MOD_ADDR_DEF = 8'h01;
    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 100;
    localparam int TICK_US = 1000;
    localparam int TICK_CYCLES = TICK_US * CLK_MHZ;
    // ------------------------------------------------------------
    // Register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [7:0] RA_CTRL = 8'h00;
    localparam logic [7:0] RA_ISTAT = 8'h04;
    localparam logic [7:0] RA_IMASK = 8'h08;
    localparam logic [7:0] RA_ACC = 8'h0c;
    localparam logic [7:0] RA_XREG = 8'h10;
    localparam logic [7:0] RA_FLAGS = 8'h14;
    localparam logic [7:0] RA_PC = 8'h18;
    localparam logic [7:0] RA_TGT_VEL = 8'h1c;
    localparam logic [7:0] RA_ACT_VEL = 8'h20;
    localparam logic [7:0] RA_IRQ_EN = 8'h24;
    localparam int IS_FRAME = 0;
    localparam int IS_SUM_ERR = 1;
    localparam int IS_ENTER = 2;
    localparam int IS_RETURN = 3;
    localparam logic [31:0] RAMP_STEP_DEF = 32'h0000_0010;
    typedef enum logic [1:0] {MCIE_STOP, MCIE_MAIN, MCIE_ISR} mcie_eng_t;
endpackage

// File: design/mcie_engine.sv
// Overview of operation
// - Enabled source with defined vector diverts program into its handler
// - Entering a handler saves accumulator, X register and flags
// - No other source is taken while a handler runs
// - Handler return restores context and resumes main program
// - Parameter write to bank 3 sets the timer interval of types 0-2
// - Rotate code 1 drives velocity positive, position increasing
// - Rotate code 2 drives velocity negative, position decreasing
// - Rotate selects velocity mode and writes target velocity in the same cycle
// - Stop code 3 ramps speed down softly
// - Stop selects velocity mode and sets target zero
// - Frame: address, instruction, type, bank, value MSB first, checksum
// - Vector numbers 0-2,3,15,21,27,28,39-41, global 255
`timescale 1ns/100ps
`default_nettype none
module mcie_engine #(
    parameter int PC_W = 16,
    parameter logic [7:0] MOD_ADDR = mcie_pkg::MOD_ADDR_DEF,
    parameter int TICK_CYCLES = mcie_pkg::TICK_CYCLES,
    parameter logic [31:0] RAMP_STEP = mcie_pkg::RAMP_STEP_DEF
) (
    input wire logic i_sys_clk,
    input wire logic i_rst_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic i_rx_valid,
    input wire logic [7:0] i_rx_data,
    output logic o_reply_valid,
    output logic [7:0] o_reply_status,
    output logic [7:0] o_reply_instr,
    input wire logic i_ins_valid,
    input wire logic [7:0] i_ins_op,
    input wire logic [7:0] i_ins_type,
    input wire logic [7:0] i_ins_bank,
    input wire logic [31:0] i_ins_value,
    output logic [PC_W-1:0] o_pc,
    input wire logic [7:0] i_event,
    output logic o_vel_mode,
    output logic [31:0] o_act_vel,
    output logic o_irq
);
    localparam int N = mcie_pkg::IRQ_SRC_N;
    localparam int T = mcie_pkg::TIMER_N;
    localparam int TW = $clog2(TICK_CYCLES + 1);
    localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);
    localparam logic [3:0] FRAME_LAST_C = mcie_pkg::FRAME_LAST;

    typedef struct packed {
        mcie_pkg::mcie_eng_t eng;
        logic [PC_W-1:0] pc;
        logic [PC_W-1:0] save_pc;
        logic [31:0] acc;
        logic [31:0] xr;
        logic [3:0] flags;
        logic [31:0] save_acc;
        logic [31:0] save_xr;
        logic [3:0] save_flags;
        logic [N-1:0] pend;
        logic [N-1:0] en;
        logic [N-1:0] vvalid;
        logic [N-1:0][PC_W-1:0] vector_define_cmd;
        logic gie;
        logic [T-1:0][31:0] tmr_int;
        logic [T-1:0][31:0] tmr_cnt;
        logic [TW-1:0] tick;
        logic vel_mode;
        logic [31:0] tgt_vel;
        logic [31:0] act_vel;
        logic [7:0][7:0] rx_buf;
        logic [3:0] rx_cnt;
        logic rep_valid;
        logic [7:0] rep_status;
        logic [7:0] rep_instr;
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
        logic [3:0] ists;
        logic [3:0] imask;
        logic irq;
    } mcie_state_t;

    mcie_state_t st_reg;
    mcie_state_t st_next;
    logic [7:0] sum;
    logic host_go;
    logic prog_go;
    logic [7:0] c_op;
    logic [31:0] c_val;
    logic [N-1:0] elig;
    logic [N-1:0] fire;
    logic [3:0] ev;
    logic wr_en;
    logic tick_hit;
    integer i;
    integer pick;

    always_comb begin
        st_next = st_reg;
        sum = 8'h00;
        host_go = 1'b0;
        prog_go = 1'b0;
        c_op = 8'h00;
        c_val = 32'h0000_0000;
        fire = '0;
        ev = 4'h0;
        pick = -1;
        wr_en = psel & penable & st_reg.pready;
        tick_hit = (st_reg.tick == TICK_LAST);
        // --------------------------------------------------------
        // Frame receiver and checksum
        // --------------------------------------------------------
        st_next.rep_valid = 1'b0;
        for (i = 0; i < 8; i = i + 1) begin
            sum = sum + st_reg.rx_buf[i];
        end
        if (i_rx_valid) begin
            if (st_reg.rx_cnt == FRAME_LAST_C) begin
                st_next.rx_cnt = 4'h0;
                if (st_reg.rx_buf[0] == MOD_ADDR) begin
                    st_next.rep_valid = 1'b1;
                    st_next.rep_instr = st_reg.rx_buf[1];
                    ev[mcie_pkg::IS_FRAME] = 1'b1;
                    if (sum != i_rx_data) begin
                        st_next.rep_status = mcie_pkg::ST_BAD_SUM;
                        ev[mcie_pkg::IS_SUM_ERR] = 1'b1;
                    end else if (st_reg.rx_buf[1] == mcie_pkg::OP_ROTATE_CW ||
                                 st_reg.rx_buf[1] == mcie_pkg::OP_ROTATE_CCW ||
                                 st_reg.rx_buf[1] == mcie_pkg::OP_SOFT_STOP) begin
                        st_next.rep_status = mcie_pkg::ST_OK;
                        host_go = 1'b1;
                        c_op = st_reg.rx_buf[1];
                        c_val = {st_reg.rx_buf[4], st_reg.rx_buf[5],
                                 st_reg.rx_buf[6], st_reg.rx_buf[7]};
                    end else begin
                        st_next.rep_status = mcie_pkg::ST_BAD_CMD;
                    end
                end
            end else begin
                st_next.rx_buf[st_reg.rx_cnt[2:0]] = i_rx_data;
                st_next.rx_cnt = st_reg.rx_cnt + 4'h1;
            end
        end
        // --------------------------------------------------------
        // Interrupt sources and timers
        // --------------------------------------------------------
        st_next.tick = tick_hit ? '0 : st_reg.tick + TW'(1);
        for (i = 0; i < T; i = i + 1) begin
            if (st_reg.tmr_int[i] == 32'h0000_0000) begin
                st_next.tmr_cnt[i] = 32'h0000_0000;
            end else if (tick_hit) begin
                if (st_reg.tmr_cnt[i] + 32'h1 >= st_reg.tmr_int[i]) begin
                    st_next.tmr_cnt[i] = 32'h0000_0000;
                    fire[i] = 1'b1;
                end else begin
                    st_next.tmr_cnt[i] = st_reg.tmr_cnt[i] + 32'h1;
                end
            end
        end
        fire[N-1:T] = i_event;
        elig = st_reg.pend & st_reg.en & st_reg.vvalid;
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (elig[i]) begin
                pick = i;
            end
        end
        // --------------------------------------------------------
        // Program sequencer and handler entry
        // --------------------------------------------------------
        if (st_reg.eng == mcie_pkg::MCIE_MAIN && st_reg.gie &&
            pick >= 0) begin
            st_next.eng = mcie_pkg::MCIE_ISR;
            st_next.save_pc = st_reg.pc;
            st_next.save_acc = st_reg.acc;
            st_next.save_xr = st_reg.xr;
            st_next.save_flags = st_reg.flags;
            st_next.pc = st_reg.vector_define_cmd[pick];
            st_next.pend[pick] = 1'b0;
            ev[mcie_pkg::IS_ENTER] = 1'b1;
        end else if (st_reg.eng != mcie_pkg::MCIE_STOP && i_ins_valid &&
                     !host_go) begin
            st_next.pc = st_reg.pc + PC_W'(1);
            case (i_ins_op)
                mcie_pkg::OP_ROTATE_CW, mcie_pkg::OP_ROTATE_CCW,
                mcie_pkg::OP_SOFT_STOP: begin
                    prog_go = 1'b1;
                    c_op = i_ins_op;
                    c_val = i_ins_value;
                end
                mcie_pkg::OP_JUMP: begin
                    st_next.pc = i_ins_value[PC_W-1:0];
                end
                mcie_pkg::OP_IRQ_ENABLE, mcie_pkg::OP_IRQ_DISABLE: begin
                    if (i_ins_type == mcie_pkg::IRQ_GLOBAL_NUM) begin
                        st_next.gie = (i_ins_op == mcie_pkg::OP_IRQ_ENABLE);
                    end
                    for (i = 0; i < N; i = i + 1) begin
                        if (i_ins_type == mcie_pkg::IRQ_NUM[i]) begin
                            st_next.en[i] =
                                (i_ins_op == mcie_pkg::OP_IRQ_ENABLE);
                        end
                    end
                end
                mcie_pkg::OP_VECTOR_DEFINE: begin
                    for (i = 0; i < N; i = i + 1) begin
                        if (i_ins_type == mcie_pkg::IRQ_NUM[i]) begin
                            st_next.vector_define_cmd[i] = i_ins_value[PC_W-1:0];
                            st_next.vvalid[i] = 1'b1;
                        end
                    end
                end
                mcie_pkg::OP_GLOBAL_PARAM_WRITE: begin
                    if (i_ins_bank == mcie_pkg::IRQ_BANK) begin
                        for (i = 0; i < T; i = i + 1) begin
                            if (i_ins_type == mcie_pkg::IRQ_NUM[i]) begin
                                st_next.tmr_int[i] = i_ins_value;
                            end
                        end
                    end
                end
                mcie_pkg::OP_HANDLER_RETURN: begin
                    if (st_reg.eng == mcie_pkg::MCIE_ISR) begin
                        st_next.eng = mcie_pkg::MCIE_MAIN;
                        st_next.pc = st_reg.save_pc;
                        st_next.acc = st_reg.save_acc;
                        st_next.xr = st_reg.save_xr;
                        st_next.flags = st_reg.save_flags;
                        ev[mcie_pkg::IS_RETURN] = 1'b1;
                    end
                end
                default: begin
                end
            endcase
        end
        // Events after entry so a same-cycle event stays pending
        st_next.pend = st_next.pend | fire;
        // --------------------------------------------------------
        // Motion commands and ramp
        // --------------------------------------------------------
        if (host_go || prog_go) begin
            st_next.vel_mode = 1'b1;
            case (c_op)
                mcie_pkg::OP_ROTATE_CW: st_next.tgt_vel = c_val;
                mcie_pkg::OP_ROTATE_CCW: st_next.tgt_vel = -c_val;
                default: st_next.tgt_vel = 32'h0000_0000;
            endcase
        end
        if ($signed(st_reg.act_vel) < $signed(st_reg.tgt_vel)) begin
            if ($signed(st_reg.tgt_vel - st_reg.act_vel) >
                $signed(RAMP_STEP)) begin
                st_next.act_vel = st_reg.act_vel + RAMP_STEP;
            end else begin
                st_next.act_vel = st_reg.tgt_vel;
            end
        end else if ($signed(st_reg.act_vel) > $signed(st_reg.tgt_vel)) begin
            if ($signed(st_reg.act_vel - st_reg.tgt_vel) >
                $signed(RAMP_STEP)) begin
                st_next.act_vel = st_reg.act_vel - RAMP_STEP;
            end else begin
                st_next.act_vel = st_reg.tgt_vel;
            end
        end
        // --------------------------------------------------------
        // APB slave
        // --------------------------------------------------------
        st_next.pready = psel & ~penable;
        st_next.pslverr = 1'b0;
        if (psel && !penable) begin
            case (paddr)
                mcie_pkg::RA_CTRL: st_next.prdata = {30'h0, st_reg.gie,
                    st_reg.eng != mcie_pkg::MCIE_STOP};
                mcie_pkg::RA_ISTAT: st_next.prdata = {28'h0, st_reg.ists};
                mcie_pkg::RA_IMASK: st_next.prdata = {28'h0, st_reg.imask};
                mcie_pkg::RA_ACC: st_next.prdata = st_reg.acc;
                mcie_pkg::RA_XREG: st_next.prdata = st_reg.xr;
                mcie_pkg::RA_FLAGS: st_next.prdata = {28'h0, st_reg.flags};
                mcie_pkg::RA_PC: st_next.prdata = 32'(st_reg.pc);
                mcie_pkg::RA_TGT_VEL: st_next.prdata = st_reg.tgt_vel;
                mcie_pkg::RA_ACT_VEL: st_next.prdata = st_reg.act_vel;
                mcie_pkg::RA_IRQ_EN: st_next.prdata = 32'(st_reg.en);
                default: begin
                    st_next.prdata = 32'h0000_0000;
                    st_next.pslverr = 1'b1;
                end
            endcase
        end
        st_next.ists = st_reg.ists;
        if (wr_en && pwrite) begin
            case (paddr)
                mcie_pkg::RA_CTRL: begin
                    if (!pwdata[0]) begin
                        st_next.eng = mcie_pkg::MCIE_STOP;
                    end else if (st_reg.eng == mcie_pkg::MCIE_STOP) begin
                        st_next.eng = mcie_pkg::MCIE_MAIN;
                        st_next.pc = '0;
                    end
                end
                mcie_pkg::RA_ISTAT: st_next.ists = st_reg.ists & ~pwdata[3:0];
                mcie_pkg::RA_IMASK: st_next.imask = pwdata[3:0];
                mcie_pkg::RA_ACC: st_next.acc = pwdata;
                mcie_pkg::RA_XREG: st_next.xr = pwdata;
                mcie_pkg::RA_FLAGS: st_next.flags = pwdata[3:0];
                default: begin
                end
            endcase
        end
        st_next.ists = st_next.ists | ev;
        st_next.irq = |(st_next.ists & st_next.imask);
    end

    always_ff @(posedge i_sys_clk) begin
        if (!i_rst_n) begin
            st_reg <= '0;
            st_reg.eng <= mcie_pkg::MCIE_STOP;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata = st_reg.prdata;
    assign pready = st_reg.pready;
    assign pslverr = st_reg.pslverr;
    assign o_reply_valid = st_reg.rep_valid;
    assign o_reply_status = st_reg.rep_status;
    assign o_reply_instr = st_reg.rep_instr;
    assign o_pc = st_reg.pc;
    assign o_vel_mode = st_reg.vel_mode;
    assign o_act_vel = st_reg.act_vel;
    assign o_irq = st_reg.irq;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence entry_s;
        st_reg.eng == mcie_pkg::MCIE_MAIN && st_reg.gie &&
            (|(st_reg.pend & st_reg.en & st_reg.vvalid));
    endsequence
    sequence in_isr_s;
        st_reg.eng == mcie_pkg::MCIE_ISR;
    endsequence

    handler_entry_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        entry_s |=> in_isr_s ##0 st_reg.ists[mcie_pkg::IS_ENTER])
        else $error("eligible source not taken");
    context_save_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        entry_s |=> st_reg.save_acc == $past(st_reg.acc) &&
            st_reg.save_xr == $past(st_reg.xr) &&
            st_reg.save_flags == $past(st_reg.flags))
        else $error("context not saved on entry");
    no_nesting_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        in_isr_s ##1 in_isr_s |-> st_reg.save_pc == $past(st_reg.save_pc))
        else $error("handler entered while in handler");
    context_restore_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        in_isr_s ##1 st_reg.eng == mcie_pkg::MCIE_MAIN && !$past(wr_en) |->
            st_reg.acc == $past(st_reg.save_acc) &&
            st_reg.pc == $past(st_reg.save_pc))
        else $error("context not restored on return");
    rotate_cw_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (host_go || prog_go) && c_op == mcie_pkg::OP_ROTATE_CW |=>
            st_reg.tgt_vel == $past(c_val) && st_reg.vel_mode)
        else $error("rotate cw target wrong");
    rotate_ccw_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (host_go || prog_go) && c_op == mcie_pkg::OP_ROTATE_CCW |=>
            st_reg.tgt_vel == -$past(c_val) && st_reg.vel_mode)
        else $error("rotate ccw target wrong");
    soft_stop_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        (host_go || prog_go) && c_op == mcie_pkg::OP_SOFT_STOP |=>
            st_reg.tgt_vel == 32'h0000_0000 && st_reg.vel_mode)
        else $error("stop did not zero target");
    ramp_soft_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        1'b1 |=> $signed(st_reg.act_vel - $past(st_reg.act_vel)) <=
            $signed(RAMP_STEP) && $signed($past(st_reg.act_vel) -
            st_reg.act_vel) <= $signed(RAMP_STEP))
        else $error("velocity jumped");
    reply_ok_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        host_go |=> o_reply_valid && o_reply_status == mcie_pkg::ST_OK)
        else $error("motion reply not ok");
    bad_sum_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        i_rx_valid && st_reg.rx_cnt == FRAME_LAST_C &&
            st_reg.rx_buf[0] == MOD_ADDR && sum != i_rx_data |=>
            o_reply_valid && o_reply_status == mcie_pkg::ST_BAD_SUM)
        else $error("checksum error not reported");
    irq_level_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
        ##1 o_irq == |(st_reg.ists & st_reg.imask))
        else $error("irq output mismatch");
endmodule
`default_nettype wire

// File: bench/mcie_host.sv
`timescale 1ns/100ps
`default_nettype none
module mcie_host (
    input wire logic i_sys_clk,
    output logic o_rx_valid,
    output logic [7:0] o_rx_data
);
    initial begin
        o_rx_valid = 1'b0;
        o_rx_data = 8'h00;
    end
    // ---------------------------------------------
    // Frame sender, optionally with a broken sum
    // ---------------------------------------------
    task automatic send(input logic [7:0] ins, input logic [31:0] v,
            input logic bad);
        logic [7:0] b [9];
        logic [7:0] sum;
        b = '{mcie_pkg::MOD_ADDR_DEF, ins, 8'h00, 8'h00, v[31:24],
            v[23:16], v[15:8], v[7:0], 8'h00};
        sum = 8'h00;
        for (int i = 0; i < 8; i++) begin
            sum = sum + b[i];
        end
        b[8] = bad ? ~sum : sum;
        for (int i = 0; i < 9; i++) begin
            @(posedge i_sys_clk);
            o_rx_valid <= 1'b1;
            o_rx_data <= b[i];
        end
        @(posedge i_sys_clk);
        o_rx_valid <= 1'b0;
        o_rx_data <= ~b[8];
    endtask
endmodule
`default_nettype wire

// File: bench/motion_cmd_interrupt_engine_test.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin \
    failures++; $display("MISMATCH %s exp %h got %h", n, e, g); end end
module motion_cmd_interrupt_engine_test;
    logic i_sys_clk, i_rst_n, psel, penable, pwrite, pready, pslverr;
    logic rx_valid, reply_valid, vel_mode, irq, ret_en, err;
    logic [7:0] paddr, rx_data, st, ri, op, ty, ev;
    logic [31:0] pwdata, prdata, val, act, rd;
    logic [15:0] pc;
    int failures = 0;
    int samples_checked = 0;
    // ---------------------------------------------
    // Program store
    // ---------------------------------------------
    always_comb begin
        op = 8'h00;
        ty = 8'h00;
        val = 32'h0;
        case (pc)
            16'h0: begin op = mcie_pkg::OP_VECTOR_DEFINE; ty = 8'h03; val = 32'h20; end
            16'h1: begin op = mcie_pkg::OP_IRQ_ENABLE; ty = 8'h03; end
            16'h2: begin op = mcie_pkg::OP_IRQ_ENABLE; ty = 8'h0f; end
            16'h3: begin op = mcie_pkg::OP_IRQ_ENABLE; ty = 8'hff; end
            16'h8: begin op = mcie_pkg::OP_JUMP; val = 32'h4; end
            16'h21: begin
                op = ret_en ? mcie_pkg::OP_HANDLER_RETURN : mcie_pkg::OP_JUMP;
                val = 32'h20;
            end
            default: ;
        endcase
    end
    mcie_engine #(.PC_W(16), .TICK_CYCLES(10)) uut (.i_sys_clk(i_sys_clk),
        .i_rst_n(i_rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .i_rx_valid(rx_valid), .i_rx_data(rx_data),
        .o_reply_valid(reply_valid), .o_reply_status(st), .o_reply_instr(ri),
        .i_ins_valid(1'b1), .i_ins_op(op), .i_ins_type(ty), .i_ins_bank(8'h00),
        .i_ins_value(val), .o_pc(pc), .i_event(ev), .o_vel_mode(vel_mode),
        .o_act_vel(act), .o_irq(irq));
    mcie_host host (.i_sys_clk(i_sys_clk), .o_rx_valid(rx_valid),
        .o_rx_data(rx_data));
    initial begin
        i_sys_clk = 1'b0;
        forever #5 i_sys_clk = ~i_sys_clk;
    end
    // ---------------------------------------------
    // Bus and helper tasks
    // ---------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_sys_clk);
        penable <= 1'b1;
        do @(posedge i_sys_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic reply(input logic [7:0] ins, input logic [31:0] v, input logic bad);
        host.send(ins, v, bad);
        for (int i = 0; i < 30; i++) begin
            @(posedge i_sys_clk);
            if (reply_valid === 1'b1) break;
        end
    endtask
    task automatic pulse(input logic [7:0] e);
        @(posedge i_sys_clk);
        ev <= e;
        @(posedge i_sys_clk);
        ev <= 8'h00;
    endtask
    task automatic results;
        $display("failures %0d samples_checked %0d", failures, samples_checked);
        if (failures == 0 && samples_checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge i_sys_clk);
        failures++;
        results();
    end
    // ---------------------------------------------
    // Test sequence
    // ---------------------------------------------
    initial begin
        {psel, penable, pwrite, paddr, pwdata, ev, ret_en} = '0;
        i_rst_n = 1'b0;
        repeat (8) @(posedge i_sys_clk);
        i_rst_n <= 1'b1;
        apb(1'b0, 8'h40, 32'h0);
        `CHK("slverr", 1'b1, err)
        reply(mcie_pkg::OP_ROTATE_CW, 32'h100, 1'b0);
        `CHK("cw st", mcie_pkg::ST_OK, st)
        `CHK("cw mode", 1'b1, vel_mode)
        apb(1'b0, mcie_pkg::RA_TGT_VEL, 32'h0);
        `CHK("cw tgt", 32'h100, rd)
        repeat (40) @(posedge i_sys_clk);
        `CHK("cw act", 32'h100, act)
        reply(mcie_pkg::OP_SOFT_STOP, 32'h0, 1'b0);
        `CHK("stop st", mcie_pkg::ST_OK, st)
        `CHK("soft", 1'b1, act != 32'h0)
        apb(1'b0, mcie_pkg::RA_TGT_VEL, 32'h0);
        `CHK("stop tgt", 32'h0, rd)
        repeat (40) @(posedge i_sys_clk);
        `CHK("stop act", 32'h0, act)
        reply(mcie_pkg::OP_ROTATE_CCW, 32'h100, 1'b0);
        `CHK("ccw in", mcie_pkg::OP_ROTATE_CCW, ri)
        repeat (40) @(posedge i_sys_clk);
        `CHK("ccw act", 32'hffff_ff00, act)
        reply(mcie_pkg::OP_ROTATE_CW, 32'h5, 1'b1);
        `CHK("sum st", mcie_pkg::ST_BAD_SUM, st)
        apb(1'b0, mcie_pkg::RA_ISTAT, 32'h0);
        `CHK("istat", 32'h3, rd)
        apb(1'b1, mcie_pkg::RA_ISTAT, 32'hf);
        apb(1'b1, mcie_pkg::RA_IMASK, 32'h4);
        apb(1'b1, mcie_pkg::RA_ACC, 32'h1234);
        apb(1'b1, mcie_pkg::RA_XREG, 32'h55);
        apb(1'b1, mcie_pkg::RA_CTRL, 32'h1);
        repeat (20) @(posedge i_sys_clk);
        pulse(8'h02);
        repeat (10) @(posedge i_sys_clk);
        `CHK("no vec", 1'b1, pc < 16'h20)
        pulse(8'h01);
        for (int i = 0; i < 20 && pc < 16'h20; i++) @(posedge i_sys_clk);
        `CHK("enter", 1'b1, pc >= 16'h20)
        repeat (2) @(posedge i_sys_clk);
        `CHK("irq", 1'b1, irq)
        apb(1'b1, mcie_pkg::RA_ACC, 32'haaaa);
        apb(1'b1, mcie_pkg::RA_XREG, 32'hbbbb);
        apb(1'b1, mcie_pkg::RA_ISTAT, 32'hf);
        pulse(8'h01);
        repeat (10) @(posedge i_sys_clk);
        `CHK("irq clr", 1'b0, irq)
        apb(1'b0, mcie_pkg::RA_ISTAT, 32'h0);
        `CHK("nest", 32'h0, rd)
        ret_en <= 1'b1;
        repeat (20) @(posedge i_sys_clk);
        apb(1'b0, mcie_pkg::RA_ISTAT, 32'h0);
        `CHK("ret", 1'b1, rd[mcie_pkg::IS_RETURN])
        apb(1'b0, mcie_pkg::RA_ACC, 32'h0);
        `CHK("acc", 32'h1234, rd)
        apb(1'b0, mcie_pkg::RA_XREG, 32'h0);
        `CHK("x", 32'h55, rd)
        `CHK("resume", 1'b1, pc < 16'h20)
        results();
    end
endmodule
`default_nettype wire
